// ---- verilog/itt_defines.svh ----
// Constants for the interval and time-base timer: register indices, field positions, reset values.
// Assumes an APB slave with 32-bit data; each register index maps to byte address index * 4.
//
// What this block does
// - Mode bits 7..5 pick system clock /32,/16,/8,/4 or watch clock /32,/16,/8,/4
// - System-derived output only in active/sleep; watch-derived also in subactive
// - Mode bit 4 is reserved, always reads one, writes ignored
// - Mode bit 3 zero: count system prescaler /8192,/4096,/2048,/512,/256,/128,/32,/8
// - Mode bits 3..2 = 10: count watch prescaler, overflow 1, 0.5, 0.25, 0.03125 s
// - Mode bits 3..2 = 11 clears counter and watch prescaler to zero
// - Counter is 8-bit up-counter, read-only, resets to zero, writes ignored
// - Counter readable in active mode; subactive read gives no valid count
// - Wrap from FF to 00 sets overflow flag; interrupt only when enabled
// - Interval mode keeps counting after wrap: overflow every 256 input clocks
// - After reset mode reads 0x10, counter zero, interval /8192 counting at once
// - Divided clock reaches its pin only while the output-enable bit is one
// - Interval counting runs in active/sleep, halts elsewhere, cleared by reset
// - Time-base counting runs in all modes except standby
// - Watch clock count edges pass a synchronizer into the system clock domain
// - Watch clock input is the 32.768 kHz oscillator feeding the time base
`ifndef ITT_DEFINES_SVH
`define ITT_DEFINES_SVH

// ----------------------------------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define ITT_IDX_MODE     16'hffb0
`define ITT_IDX_COUNT    16'hffb1
`define ITT_IDX_STATUS   16'hffb8
`define ITT_IDX_IRQ_EN   16'hffb9
`define ITT_IDX_PORT     16'hffba

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define ITT_MODE_RST     8'h10
`define ITT_MODE_RSVD    4
`define ITT_COUNT_RST    8'h00
`define ITT_COUNT_MAX    8'hff
`define ITT_FLAG_BIT     0
`define ITT_OUT_EN_BIT   0
`define ITT_OUT_TOP_BIT  3'h4

// ----------------------------------------------------------------
// Prescaler widths (log2 of largest division) and watch clock frequency
// ----------------------------------------------------------------
`define ITT_PSS_W        13
`define ITT_PSW_W        7
`define ITT_WATCH_HZ     32768

`endif

// ---- verilog/itt_pkg.sv ----
// Types for the interval and time-base timer.
// Assumes itt_defines.svh is on the include path.
`include "itt_defines.svh"

package itt_pkg;

  // Chip power state, driven by the power controller
  typedef enum logic [2:0] {
    ITT_PWR_ACTIVE    = 3'h0,
    ITT_PWR_SLEEP     = 3'h1,
    ITT_PWR_WATCH     = 3'h2,
    ITT_PWR_SUBACTIVE = 3'h3,
    ITT_PWR_SUBSLEEP  = 3'h4,
    ITT_PWR_STANDBY   = 3'h5
  } itt_pwr_t;

  typedef struct packed {
    logic [7:0]               mode;
    logic [7:0]               count;
    logic [`ITT_PSS_W-1:0]    system_prescaler;
    logic [`ITT_PSW_W-1:0]    watch_prescaler;
    logic                     ws1;
    logic                     ws2;
    logic                     ws3;
    logic                     ovf_flag;
    logic                     ovf_en;
    logic                     out_en;
    logic                     clk_out;
    logic                     irq;
    logic [31:0]              prdata;
    logic                     pready;
    logic                     pslverr;
  } itt_state_t;

endpackage : itt_pkg

// ---- verilog/itt_top.sv ----
// Interval and time-base timer with divided clock output, APB register slave.
// Assumes all inputs synchronous to core_clk except watch_clk, which is synchronized here.
`timescale 1ns/1ns
`include "itt_defines.svh"

module itt_top
(
  input  wire logic                core_clk,
  input  wire logic                arst_n,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [17:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire itt_pkg::itt_pwr_t   pwr_mode,
  input  wire logic                watch_clk,
  output logic                     divided_clock_output,
  output logic                     irq
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // True when the low n bits of v are all ones, i.e. the next increment carries out of them
  function automatic logic low_ones(input logic [12:0] v, input logic [3:0] n);
    logic [12:0] mask;
    mask = 13'((14'h0001 << n) - 14'h0001);
    return &(v | ~mask);
  endfunction : low_ones

  itt_pkg::itt_state_t st_q;
  itt_pkg::itt_state_t st_d;

  logic        pss_run;
  logic        psw_run;
  logic        out_w_ok;
  logic        wedge;
  logic        clear_tb;
  logic        tick;
  logic [3:0]  tap;
  logic [2:0]  oidx;
  logic        obit;
  logic        access;
  logic        wr;
  logic        addr_ok;
  logic [15:0] idx;
  logic        flag_set;
  logic        flag_clr;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_d     = st_q;
    tap      = 4'h0;
    tick     = 1'b0;
    flag_set = 1'b0;
    flag_clr = 1'b0;
    obit     = 1'b0;

    pss_run  = (pwr_mode == itt_pkg::ITT_PWR_ACTIVE) || (pwr_mode == itt_pkg::ITT_PWR_SLEEP);
    psw_run  = (pwr_mode != itt_pkg::ITT_PWR_STANDBY);
    out_w_ok = pss_run || (pwr_mode == itt_pkg::ITT_PWR_SUBACTIVE);

    // System prescaler free-runs only while the system clock is on
    if (pss_run)
    begin
      st_d.system_prescaler = st_q.system_prescaler + 13'h0001;
    end

    // Watch clock edges enter through two flops; the second and a third flop behind it feed the edge detect
    st_d.ws1 = watch_clk;
    st_d.ws2 = st_q.ws1;
    st_d.ws3 = st_q.ws2;
    wedge    = st_q.ws2 & ~st_q.ws3;

    clear_tb = (st_q.mode[3:2] == 2'b11);

    if (!st_q.mode[3])
    begin
      case (st_q.mode[2:0])
        3'h0:    tap = 4'hd;
        3'h1:    tap = 4'hc;
        3'h2:    tap = 4'hb;
        3'h3:    tap = 4'h9;
        3'h4:    tap = 4'h8;
        3'h5:    tap = 4'h7;
        3'h6:    tap = 4'h5;
        default: tap = 4'h3;
      endcase
      tick = pss_run && low_ones(st_q.system_prescaler, tap);
    end
    else if (!st_q.mode[2])
    begin
      // 256 Hz into the counter gives 1 s; shorter taps give the faster periods
      case (st_q.mode[1:0])
        2'h0:    tap = 4'h7;
        2'h1:    tap = 4'h6;
        2'h2:    tap = 4'h5;
        default: tap = 4'h2;
      endcase
      tick = psw_run && wedge && low_ones({6'h00, st_q.watch_prescaler}, tap);
    end

    if (clear_tb)
    begin
      st_d.watch_prescaler   = '0;
      st_d.count = `ITT_COUNT_RST;
    end
    else
    begin
      if (psw_run && wedge)
      begin
        st_d.watch_prescaler = st_q.watch_prescaler + 7'h01;
      end
      if (tick)
      begin
        st_d.count = st_q.count + 8'h01;
        flag_set   = (st_q.count == `ITT_COUNT_MAX);
      end
    end

    // Divided clock output; gated off when its source clock is stopped
    oidx = 3'(`ITT_OUT_TOP_BIT - {1'b0, st_q.mode[6:5]});
    if (!st_q.mode[7])
    begin
      obit = pss_run & st_q.system_prescaler[oidx];
    end
    else
    begin
      obit = out_w_ok & st_q.watch_prescaler[oidx];
    end
    st_d.clk_out = st_q.out_en & obit;

    // APB slave: one wait state, answer registered
    access       = psel && penable && !st_q.pready;
    wr           = access && pwrite;
    idx          = paddr[17:2];
    addr_ok      = (paddr[1:0] == 2'b00) &&
                   ((idx == `ITT_IDX_MODE) || (idx == `ITT_IDX_COUNT) || (idx == `ITT_IDX_STATUS) ||
                    (idx == `ITT_IDX_IRQ_EN) || (idx == `ITT_IDX_PORT));
    st_d.pready  = access;
    st_d.pslverr = access && !addr_ok;
    if (access && !pwrite)
    begin
      st_d.prdata = 32'h0000_0000;
      if (addr_ok)
      begin
        case (idx)
          `ITT_IDX_MODE:   st_d.prdata[7:0] = st_q.mode | 8'h10;
          `ITT_IDX_COUNT:  st_d.prdata[7:0] =
                             (pwr_mode == itt_pkg::ITT_PWR_SUBACTIVE) ? 8'h00 : st_q.count;
          `ITT_IDX_STATUS: st_d.prdata[`ITT_FLAG_BIT] = st_q.ovf_flag;
          `ITT_IDX_IRQ_EN: st_d.prdata[`ITT_FLAG_BIT] = st_q.ovf_en;
          default:         st_d.prdata[`ITT_OUT_EN_BIT] = st_q.out_en;
        endcase
      end
    end
    if (wr && addr_ok)
    begin
      case (idx)
        `ITT_IDX_MODE:   st_d.mode = {pwdata[7:5], 1'b1, pwdata[3:0]};
        `ITT_IDX_STATUS: flag_clr = pwdata[`ITT_FLAG_BIT];
        `ITT_IDX_IRQ_EN: st_d.ovf_en = pwdata[`ITT_FLAG_BIT];
        `ITT_IDX_PORT:   st_d.out_en = pwdata[`ITT_OUT_EN_BIT];
        default:         st_d.ovf_en = st_q.ovf_en;
      endcase
    end

    // Set wins over a same-cycle clear so no overflow is lost
    st_d.ovf_flag = (st_q.ovf_flag & ~flag_clr) | flag_set;
    st_d.irq      = st_d.ovf_flag & st_d.ovf_en;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q       <= '0;
      st_q.mode  <= `ITT_MODE_RST;
      st_q.count <= `ITT_COUNT_RST;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign prdata               = st_q.prdata;
  assign pready               = st_q.pready;
  assign pslverr              = st_q.pslverr;
  assign divided_clock_output = st_q.clk_out;
  assign irq                  = st_q.irq;

endmodule : itt_top

// ---- verification/itt_top_sva.sv ----
// Port-level checker for the interval and time-base timer.
// Assumes it is bound to itt_top; sees only its ports.
`timescale 1ns/1ns

module itt_top_sva
(
  input wire logic              core_clk,
  input wire logic              arst_n,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire itt_pkg::itt_pwr_t pwr_mode,
  input wire logic              divided_clock_output,
  input wire logic              irq
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  a_rdy_pulse: assert property (pready |=> !pready) else $error("pready held too long");
  a_rdy_after_acc: assert property (psel && penable && !pready |=> pready) else $error("no answer");
  a_no_rdy_idle: assert property (!(psel && penable) |=> !pready) else $error("answer without access");
  a_err_with_rdy: assert property (pslverr |-> pready) else $error("pslverr without pready");
  a_rd_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("refused read returned data");
  a_rd_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  a_rst_quiet: assert property ($rose(arst_n) |-> !irq && !divided_clock_output)
    else $error("outputs active after reset");
  a_irq_fall_write: assert property ($fell(irq) |-> pready && pwrite)
    else $error("irq dropped without a write");
  a_out_stopped: assert property ((pwr_mode inside {itt_pkg::ITT_PWR_WATCH,
    itt_pkg::ITT_PWR_SUBSLEEP, itt_pkg::ITT_PWR_STANDBY}) [*3] |-> !divided_clock_output)
    else $error("clock output in stopped mode");
endmodule : itt_top_sva

// ---- verification/itt_top_tb_top.sv ----
// Self-checking bench for the interval and time-base timer.
// Assumes itt_pkg and itt_defines.svh are compiled and on the include path.
`timescale 1ns/1ns
`include "itt_defines.svh"

module itt_top_tb_top;
  // ----------------------------------------------------------------
  // Stimulus and checks
  // ----------------------------------------------------------------
  localparam logic [17:0] A_MODE = {`ITT_IDX_MODE, 2'b00};
  localparam logic [17:0] A_CNT  = {`ITT_IDX_COUNT, 2'b00};
  localparam logic [17:0] A_STAT = {`ITT_IDX_STATUS, 2'b00};
  localparam logic [17:0] A_EN   = {`ITT_IDX_IRQ_EN, 2'b00};
  localparam logic [17:0] A_PORT = {`ITT_IDX_PORT, 2'b00};
  logic core_clk, arst_n, psel, penable, pwrite, pready, pslverr, watch_clk, divided_clock_output, irq;
  logic [17:0]       paddr;
  logic [31:0]       pwdata, prdata, rd, r1;
  logic              er;
  itt_pkg::itt_pwr_t pwr_mode;
  int                n_fail = 0, samples_checked = 0, nr;
  time               t0;

  itt_top u_dut (.core_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .pwr_mode, .watch_clk, .divided_clock_output, .irq);

  initial begin core_clk = 0; forever #5 core_clk = ~core_clk; end
  // Watch clock free-runs, unrelated to core_clk
  initial begin watch_clk = 0; forever #15259 watch_clk = ~watch_clk; end

  task give_verdict;
    if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask : chk

  task apb(input logic w, input logic [17:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    n = 0;
    do begin @(posedge core_clk); n++; end while (pready !== 1'b1 && n < 20);
    rd = prdata; er = pslverr; psel <= 0; penable <= 0;
    if (n >= 20) begin chk("apb timeout", 0, 1); give_verdict; end
  endtask : apb

  task wait_flag;
    int n;
    n = 0; rd = 0;
    while (rd[0] !== 1'b1 && n < 1000) begin apb(0, A_STAT, 0); n++; end
    if (n >= 1000) begin chk("flag timeout", 0, 1); give_verdict; end
  endtask : wait_flag

  task rises;
    logic p;
    repeat (4) @(posedge core_clk);
    nr = 0; p = divided_clock_output;
    repeat (128) begin @(posedge core_clk); nr += (divided_clock_output && !p); p = divided_clock_output; end
  endtask : rises

  task t_regs;
    apb(0, A_MODE, 0); chk("mode reset", 32'h0000_0010, rd);
    apb(0, A_CNT, 0); chk("count reset", 0, rd);
    apb(0, A_PORT, 0); chk("port reset", 0, rd);
    apb(1, A_MODE, 0); apb(0, A_MODE, 0); chk("mode bit4", 32'h0000_0010, rd);
    apb(1, A_MODE, 32'h0000_00ef); apb(0, A_MODE, 0); chk("mode all", 32'h0000_00ff, rd);
    apb(1, A_CNT, 32'h0000_0055); apb(0, A_CNT, 0); chk("count ro", 0, rd);
    apb(0, 18'h3_ff00, 0); chk("unmapped", 1, er);
  endtask : t_regs

  task t_ovf;
    apb(1, A_MODE, 32'h0000_001c); apb(0, A_CNT, 0); chk("count clear", 0, rd);
    apb(1, A_STAT, 1);
    apb(1, A_MODE, 32'h0000_0017); t0 = $time;
    wait_flag; chk("first ovf", 1, ($time - t0) / 10 inside {[2030:2065]});
    t0 = $time;
    apb(1, A_EN, 1); chk("irq on", 1, irq);
    apb(1, A_EN, 0); chk("irq masked", 0, irq);
    apb(1, A_EN, 1); apb(1, A_STAT, 1); chk("irq clear", 0, irq);
    apb(0, A_STAT, 0); chk("flag clear", 0, rd);
    wait_flag; chk("ovf period", 1, ($time - t0) / 10 inside {[2040:2056]});
    apb(1, A_STAT, 1); apb(1, A_EN, 0);
  endtask : t_ovf

  task t_power;
    pwr_mode <= itt_pkg::ITT_PWR_WATCH;
    apb(0, A_CNT, 0); r1 = rd; repeat (50) @(posedge core_clk);
    apb(0, A_CNT, 0); chk("halt watch", r1, rd);
    pwr_mode <= itt_pkg::ITT_PWR_SUBACTIVE;
    apb(0, A_CNT, 0); chk("subactive read", 0, rd);
    pwr_mode <= itt_pkg::ITT_PWR_WATCH;
    apb(1, A_MODE, 32'h0000_001c); apb(1, A_MODE, 32'h0000_001b);
    repeat (30000) @(posedge core_clk);
    apb(0, A_CNT, 0); chk("time base", 2, rd);
    pwr_mode <= itt_pkg::ITT_PWR_ACTIVE;
  endtask : t_power

  task t_clkout;
    apb(1, A_MODE, 32'h0000_0077); rises; chk("out disabled", 0, nr);
    apb(1, A_PORT, 1);
    for (int c = 0; c < 4; c++)
    begin
      apb(1, A_MODE, {24'h00_0000, c[2:0], 5'h17}); rises; chk("out rises", 4 << c, nr);
    end
    pwr_mode <= itt_pkg::ITT_PWR_SUBACTIVE; rises; chk("out subactive", 0, nr);
    // Watch-derived /4 keeps running in subactive; one period is about 12200 core cycles
    apb(1, A_MODE, 32'h0000_00f7);
    nr = 0; r1 = {31'h0000_0000, divided_clock_output};
    repeat (30000)
    begin
      @(posedge core_clk);
      nr += (divided_clock_output && !r1[0]);
      r1 = {31'h0000_0000, divided_clock_output};
    end
    chk("out watch", 1, nr inside {[2:3]});
    pwr_mode <= itt_pkg::ITT_PWR_ACTIVE;
  endtask : t_clkout

  initial
  begin
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; arst_n = 0;
    pwr_mode = itt_pkg::ITT_PWR_ACTIVE;
    repeat (3) @(posedge core_clk);
    arst_n <= 1;
    t_regs;
    t_ovf;
    t_power;
    t_clkout;
    give_verdict;
  end
endmodule : itt_top_tb_top

bind itt_top itt_top_sva u_sva (.core_clk, .arst_n, .psel, .penable, .pwrite, .prdata, .pready,
  .pslverr, .pwr_mode, .divided_clock_output, .irq);
